// >>> bench/host_line_model.sv
`timescale 1ns/1ps
module host_line_model (
    input wire logic core_clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready
);
    logic [7:0] got[$];

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end

    // collect reply characters as the reply sink takes them
    always @(posedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_data);
        end
    end

    // letter, arguments, then cr lf; each byte held until taken
    task automatic send_line(input string s, output bit stuck);
        int n;
        stuck = 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < s.len() + 2; i++) begin
            rx_valid <= 1'b1;
            if (i < s.len()) begin
                rx_data <= s[i];
            end else begin
                rx_data <= (i == s.len()) ? 8'h0d : 8'h0a;
            end
            n = 0;
            @(negedge core_clk);
            while (rx_ready !== 1'b1 && n < 4000) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 4000) begin
                stuck = 1'b1;
            end
            @(posedge core_clk);
        end
        // released line shows no stale value
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

// >>> bench/test_calib_config_cmd_parser.sv
`timescale 1ns/1ps
module test_calib_config_cmd_parser;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] rx_data;
    logic rx_valid, rx_ready, tx_valid, zero_cal_req, az_enable;
    logic [7:0] tx_data;
    logic tx_ready = 1'b0;
    logic zero_cal_done = 1'b0;
    logic [15:0] zero_value = 16'h0000;
    logic [15:0] zero_cal_conc, autozero_bg_conc, fresh_air_conc;
    logic [16:0] altitude_comp;
    logic [9:0] az_initial_tenths, az_regular_tenths;
    logic [31:0] rnd = 32'h00004bcd;
    logic [15:0] cal_seen;
    int cal_cnt = 0;
    int mismatches = 0;
    int comparisons = 0;
    int v, w, b, zv;

    always #25 core_clk = ~core_clk;

    calib_config_cmd_parser dut (.core_clk(core_clk), .rstn(rstn),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .zero_cal_req(zero_cal_req), .zero_cal_conc(zero_cal_conc),
        .zero_cal_done(zero_cal_done), .zero_value(zero_value),
        .autozero_bg_conc(autozero_bg_conc),
        .fresh_air_conc(fresh_air_conc), .altitude_comp(altitude_comp),
        .az_initial_tenths(az_initial_tenths),
        .az_regular_tenths(az_regular_tenths), .az_enable(az_enable));

    host_line_model host (.core_clk(core_clk), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // random stalls of the reply sink
    always @(posedge core_clk) begin
        rnd <= lfsr_next(rnd);
        tx_ready <= rnd[2] | rnd[5];
    end

    // calibration core: finishes a few cycles after each request
    always @(posedge core_clk) begin
        zero_cal_done <= (cal_cnt == 1);
        if (zero_cal_req === 1'b1) begin
            cal_cnt <= 6;
            cal_seen <= zero_cal_conc;
        end else if (cal_cnt > 0) begin
            cal_cnt <= cal_cnt - 1;
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [16:0] exp,
                       input logic [16:0] seen);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // send a line; an empty reply means the line must be ignored
    task automatic cmd(input string line, input string exp);
        bit stuck;
        int n;
        string e;
        host.send_line(line, stuck);
        if (stuck) begin
            mismatches++;
            tally_and_finish();
        end
        if (exp.len() > 0) begin
            e = {exp, "\r\n"};
            n = 0;
            while (!(host.got.size() > 0 && host.got[$] === 8'h0a)
                   && n < 4000) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 4000) begin
                mismatches++;
                tally_and_finish();
            end
            chk("reply length", 17'(e.len()), 17'(host.got.size()));
            for (int i = 0; i < e.len() && i < host.got.size(); i++) begin
                chk("reply byte", {9'h000, e[i]}, {9'h000, host.got[i]});
            end
            host.got.delete();
        end
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk("altitude_comp", 17'h02000, altitude_comp);
        chk("autozero_bg_conc", 17'd400, {1'b0, autozero_bg_conc});
        chk("fresh_air_conc", 17'd400, {1'b0, fresh_air_conc});
        chk("az_enable", 17'h00000, {16'h0000, az_enable});
        chk("tx_valid", 17'h00000, {16'h0000, tx_valid});
        chk("rx_ready", 17'h00001, {16'h0000, rx_ready});
        chk("zero_cal_req", 17'h00000, {16'h0000, zero_cal_req});
        $display("test reset done");

        cmd("S 65536", "S 65536");
        cmd("S 65537", "");
        cmd("s", "s 65536");
        cmd("S 8192", "S 08192");
        chk("altitude_comp", 17'h02000, altitude_comp);
        $display("test altitude done");

        v = int'(rnd[15:0]);
        w = int'(rnd[31:16]);
        for (int k = 8; k < 12; k++) begin
            b = (k % 2 == 0) ? ((k < 10 ? v : w) / 256)
                             : ((k < 10 ? v : w) % 256);
            cmd($sformatf("P %0d %0d", k, b),
                $sformatf("P %05d %05d", k, b));
        end
        cmd("P 12 3", "");
        cmd("P 8 256", "");
        cmd("Q 5", "");
        chk("autozero_bg_conc", 17'(v), {1'b0, autozero_bg_conc});
        chk("fresh_air_conc", 17'(w), {1'b0, fresh_air_conc});
        $display("test background done");

        zv = int'(rnd[15:0]);
        v = int'(rnd[31:16]);
        @(posedge core_clk);
        zero_value <= zv[15:0];
        cmd($sformatf("X %0d", v), $sformatf("X %05d", zv));
        chk("zero_cal_conc", 17'(v), {1'b0, cal_seen});
        cmd("G", $sformatf("G %05d", zv));
        chk("zero_cal_conc", 17'(w), {1'b0, cal_seen});
        $display("test zero done");

        v = int'(rnd[9:0]) % 1000;
        w = int'(rnd[25:16]) % 1000;
        cmd($sformatf("@ %0d.%0d %0d.%0d", v / 10, v % 10, w / 10, w % 10),
            $sformatf("@ %0d.%0d %0d.%0d", v / 10, v % 10, w / 10,
                      w % 10));
        chk("az_initial_tenths", 17'(v), {7'h00, az_initial_tenths});
        chk("az_regular_tenths", 17'(w), {7'h00, az_regular_tenths});
        cmd("@ 1.0 8.0", "@ 1.0 8.0");
        cmd("@ 1.00 2.0", "");
        chk("az_enable", 17'h00001, {16'h0000, az_enable});
        chk("az_regular_tenths", 17'd80, {7'h00, az_regular_tenths});
        cmd("@ 0", "@ 0.0");
        chk("az_enable", 17'h00000, {16'h0000, az_enable});
        chk("az_initial_tenths", 17'h00000, {7'h00, az_initial_tenths});
        $display("test intervals done");
        tally_and_finish();
    end
endmodule

// >>> hdl/calib_config_cmd_parser.sv
`timescale 1ns/1ps
module calib_config_cmd_parser (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic zero_cal_req,
    output logic [15:0] zero_cal_conc,
    input wire logic zero_cal_done,
    input wire logic [15:0] zero_value,
    output logic [15:0] autozero_bg_conc,
    output logic [15:0] fresh_air_conc,
    output logic [16:0] altitude_comp,
    output logic [9:0] az_initial_tenths,
    output logic [9:0] az_regular_tenths,
    output logic az_enable
);
    cmd_pkg::parse_st_t st_q, st_d;
    logic [7:0] let_q, let_d;
    logic [1:0] argn_q, argn_d;
    logic [16:0] acc_q [2];
    logic [16:0] acc_d [2];
    logic has_q [2];
    logic has_d [2];
    logic dot_q [2];
    logic dot_d [2];
    logic [1:0] fr_q [2];
    logic [1:0] fr_d [2];
    logic [15:0] bg_q, bg_d, fa_q, fa_d, calc_q, calc_d;
    logic [16:0] alt_q, alt_d;
    logic [9:0] ini_q, ini_d, reg_q, reg_d;
    logic req_q, req_d;
    logic [7:0] cal_let_q, cal_let_d;
    logic tx_busy, tx_start, rx_take;
    logic [7:0] r_letter;
    logic [1:0] r_nf;
    logic r_tenths;
    logic [16:0] r_f0, r_f1;
    logic is_digit, cur_ok, do_x, do_g, do_p, do_s, do_sr, do_at, do_off;
    logic [16:0] x_conc;
    logic [1:0] cur;
    logic [20:0] prod;

    // argument accumulation and decode of a complete line
    always_comb begin
        is_digit = (rx_data >= cmd_pkg::CH_0) && (rx_data <= cmd_pkg::CH_9);
        cur = argn_q - 2'h1;
        cur_ok = (argn_q != 2'h0);
        prod = {4'h0, acc_q[cur[0]]} * 21'h0000a
             + {17'h00000, rx_data[3:0]};
        x_conc = acc_q[0] * cmd_pkg::CONC_MULT;
        do_x = (let_q == cmd_pkg::CH_X) && argn_q == 2'h1 && has_q[0]
            && !dot_q[0] && x_conc <= cmd_pkg::CONC_MAX;
        do_g = (let_q == cmd_pkg::CH_G) && argn_q == 2'h0;
        do_p = (let_q == cmd_pkg::CH_P) && argn_q == 2'h2 && has_q[0]
            && has_q[1] && !dot_q[0] && !dot_q[1]
            && acc_q[1] <= cmd_pkg::BYTE_MAX
            && acc_q[0] >= cmd_pkg::IDX_BG_HI
            && acc_q[0] <= cmd_pkg::IDX_FA_LO;
        do_s = (let_q == cmd_pkg::CH_S) && argn_q == 2'h1 && has_q[0]
            && !dot_q[0] && acc_q[0] <= cmd_pkg::ALT_MAX;
        do_sr = (let_q == cmd_pkg::CH_SR) && argn_q == 2'h0;
        do_at = (let_q == cmd_pkg::CH_AT) && argn_q == 2'h2
            && dot_q[0] && dot_q[1] && fr_q[0] == 2'h1 && fr_q[1] == 2'h1
            && acc_q[0] <= cmd_pkg::TENTHS_MAX
            && acc_q[1] <= cmd_pkg::TENTHS_MAX;
        do_off = (let_q == cmd_pkg::CH_AT) && argn_q == 2'h1 && has_q[0]
            && !dot_q[0] && acc_q[0] == 17'h00000;
        if (!(st_q == cmd_pkg::ST_LF && rx_take && rx_data == cmd_pkg::CH_LF))
        begin
            do_x = 1'b0;
            do_g = 1'b0;
            do_p = 1'b0;
            do_s = 1'b0;
            do_sr = 1'b0;
            do_at = 1'b0;
            do_off = 1'b0;
        end
    end

    // parser state, stored settings and calibration handshake
    always_comb begin
        st_d = st_q;
        let_d = let_q;
        argn_d = argn_q;
        acc_d = acc_q;
        has_d = has_q;
        dot_d = dot_q;
        fr_d = fr_q;
        bg_d = bg_q;
        fa_d = fa_q;
        alt_d = alt_q;
        ini_d = ini_q;
        reg_d = reg_q;
        calc_d = calc_q;
        cal_let_d = cal_let_q;
        req_d = 1'b0;
        tx_start = 1'b0;
        r_letter = let_q;
        r_nf = 2'h1;
        r_tenths = 1'b0;
        r_f0 = acc_q[0];
        r_f1 = acc_q[1];
        if (rx_take) begin
            case (st_q)
                cmd_pkg::ST_LETTER: begin
                    let_d = rx_data;
                    argn_d = 2'h0;
                    for (int i = 0; i < 2; i++) begin
                        acc_d[i] = 17'h00000;
                        has_d[i] = 1'b0;
                        dot_d[i] = 1'b0;
                        fr_d[i] = 2'h0;
                    end
                    st_d = (rx_data == cmd_pkg::CH_CR) ? cmd_pkg::ST_LETTER
                         : (rx_data == cmd_pkg::CH_LF) ? cmd_pkg::ST_LETTER
                         : cmd_pkg::ST_BODY;
                end
                cmd_pkg::ST_BODY: begin
                    if (rx_data == cmd_pkg::CH_CR) begin
                        st_d = cmd_pkg::ST_LF;
                    end else if (rx_data == cmd_pkg::CH_SP) begin
                        if (argn_q == 2'h2) begin
                            st_d = cmd_pkg::ST_DISCARD;
                        end else if (argn_q == 2'h0 || has_q[cur[0]]) begin
                            argn_d = argn_q + 2'h1;
                        end
                    end else if (is_digit && cur_ok) begin
                        acc_d[cur[0]] = (prod > 21'h01ffff) ? 17'h1ffff
                                      : prod[16:0];
                        has_d[cur[0]] = 1'b1;
                        if (dot_q[cur[0]] && fr_q[cur[0]] != 2'h3) begin
                            fr_d[cur[0]] = fr_q[cur[0]] + 2'h1;
                        end
                    end else if (rx_data == cmd_pkg::CH_DOT && cur_ok
                                 && has_q[cur[0]] && !dot_q[cur[0]]) begin
                        dot_d[cur[0]] = 1'b1;
                    end else begin
                        st_d = cmd_pkg::ST_DISCARD;
                    end
                end
                cmd_pkg::ST_LF: begin
                    st_d = cmd_pkg::ST_LETTER;
                    if (rx_data != cmd_pkg::CH_LF) begin
                        st_d = cmd_pkg::ST_DISCARD;
                    end else if (do_x || do_g) begin
                        st_d = cmd_pkg::ST_CAL;
                        req_d = 1'b1;
                        cal_let_d = let_q;
                        calc_d = do_x ? x_conc[15:0] : fa_q;
                    end else if (do_p) begin
                        case (acc_q[0][1:0])
                            2'h0: bg_d[15:8] = acc_q[1][7:0];
                            2'h1: bg_d[7:0] = acc_q[1][7:0];
                            2'h2: fa_d[15:8] = acc_q[1][7:0];
                            default: fa_d[7:0] = acc_q[1][7:0];
                        endcase
                        tx_start = 1'b1;
                        r_nf = 2'h2;
                    end else if (do_s || do_sr) begin
                        if (do_s) begin
                            alt_d = acc_q[0];
                        end
                        r_f0 = do_s ? acc_q[0] : alt_q;
                        tx_start = 1'b1;
                    end else if (do_at || do_off) begin
                        ini_d = do_at ? acc_q[0][9:0] : 10'h000;
                        reg_d = do_at ? acc_q[1][9:0] : 10'h000;
                        r_nf = do_at ? 2'h2 : 2'h1;
                        r_tenths = 1'b1;
                        tx_start = 1'b1;
                    end
                end
                cmd_pkg::ST_DISCARD: begin
                    if (rx_data == cmd_pkg::CH_LF) begin
                        st_d = cmd_pkg::ST_LETTER;
                    end
                end
                default: st_d = cmd_pkg::ST_LETTER;
            endcase
        end
        // reply to a calibration once the core reports the new zero
        if (st_q == cmd_pkg::ST_CAL && zero_cal_done && !tx_busy) begin
            st_d = cmd_pkg::ST_LETTER;
            tx_start = 1'b1;
            r_letter = cal_let_q;
            r_f0 = {1'b0, zero_value};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= cmd_pkg::ST_LETTER;
            let_q <= 8'h00;
            argn_q <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                acc_q[i] <= 17'h00000;
                has_q[i] <= 1'b0;
                dot_q[i] <= 1'b0;
                fr_q[i] <= 2'h0;
            end
            bg_q <= cmd_pkg::CONC_RESET;
            fa_q <= cmd_pkg::CONC_RESET;
            alt_q <= cmd_pkg::ALT_RESET;
            ini_q <= cmd_pkg::TENTHS_RESET;
            reg_q <= cmd_pkg::TENTHS_RESET;
            calc_q <= 16'h0000;
            cal_let_q <= 8'h00;
            req_q <= 1'b0;
        end else begin
            st_q <= st_d;
            let_q <= let_d;
            argn_q <= argn_d;
            acc_q <= acc_d;
            has_q <= has_d;
            dot_q <= dot_d;
            fr_q <= fr_d;
            bg_q <= bg_d;
            fa_q <= fa_d;
            alt_q <= alt_d;
            ini_q <= ini_d;
            reg_q <= reg_d;
            calc_q <= calc_d;
            cal_let_q <= cal_let_d;
            req_q <= req_d;
        end
    end

    // no new byte while a reply or calibration is outstanding
    assign rx_ready = !tx_busy && st_q != cmd_pkg::ST_CAL;
    assign rx_take = rx_valid && rx_ready;
    assign zero_cal_req = req_q;
    assign zero_cal_conc = calc_q;
    assign autozero_bg_conc = bg_q;
    assign fresh_air_conc = fa_q;
    assign altitude_comp = alt_q;
    assign az_initial_tenths = ini_q;
    assign az_regular_tenths = reg_q;
    assign az_enable = (ini_q != 10'h000) || (reg_q != 10'h000);

    reply_tx u_reply (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(tx_start),
        .letter(r_letter),
        .nfield(r_nf),
        .fmt_tenths(r_tenths),
        .field0(r_f0),
        .field1(r_f1),
        .busy(tx_busy),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_X_CAL_REQ: assert property (
        do_x |=> zero_cal_req && zero_cal_conc == $past(x_conc[15:0]))
        else $error("X line did not request calibration with its value");
    AST_G_FRESH: assert property (
        do_g |=> zero_cal_req && zero_cal_conc == $past(fa_q))
        else $error("G calibration not at fresh-air concentration");
    AST_P_BG_LO: assert property (
        do_p && acc_q[0] == cmd_pkg::IDX_BG_LO
        |=> autozero_bg_conc[7:0] == $past(acc_q[1][7:0])
            && autozero_bg_conc[15:8] == $past(bg_q[15:8]))
        else $error("P 9 did not load background low byte");
    AST_P_FA_HI: assert property (
        do_p && acc_q[0] == cmd_pkg::IDX_FA_HI
        |=> fresh_air_conc[15:8] == $past(acc_q[1][7:0]))
        else $error("P 10 did not load fresh-air high byte");
    AST_ALT_STORE: assert property (
        do_s |=> altitude_comp == $past(acc_q[0]) ##[1:4] tx_valid
            && tx_data == cmd_pkg::CH_S)
        else $error("S value not stored and echoed");
    AST_ALT_RESET: assert property (@(posedge core_clk)
        disable iff (1'b0) !rstn |=> altitude_comp == cmd_pkg::ALT_RESET)
        else $error("altitude not at default after reset");
    AST_SR_REPLY: assert property (
        do_sr |-> ##[1:3] tx_valid && tx_data == cmd_pkg::CH_SR)
        else $error("s query got no reply letter");
    AST_AT_STORE: assert property (
        do_at |=> az_initial_tenths == $past(acc_q[0][9:0])
            && az_regular_tenths == $past(acc_q[1][9:0])
            && az_enable == ($past(acc_q[0][9:0]) != 10'h000
                             || $past(acc_q[1][9:0]) != 10'h000))
        else $error("@ intervals not stored");
    AST_BUSY_BLOCKS: assert property (
        tx_busy || st_q == cmd_pkg::ST_CAL |-> !rx_ready)
        else $error("byte accepted during reply or calibration");
    AST_CAL_REPLY: assert property (
        st_q == cmd_pkg::ST_CAL && zero_cal_done && !tx_busy
        |-> ##[1:3] tx_valid && tx_data == cal_let_q)
        else $error("calibration reply missing");

    COV_X: cover property (do_x ##[1:20] zero_cal_done);
    COV_P: cover property (do_p ##[1:300] do_p);
    COV_AT: cover property (do_at);
    COV_SR: cover property (do_sr);
endmodule

// >>> hdl/reply_tx.sv
`timescale 1ns/1ps
module reply_tx (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] letter,
    input wire logic [1:0] nfield,
    input wire logic fmt_tenths,
    input wire logic [16:0] field0,
    input wire logic [16:0] field1,
    output logic busy,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    logic active_q, active_d;
    logic valid_q, valid_d;
    logic [7:0] byte_q, byte_d;
    logic [3:0] pos_q, pos_d;
    logic [7:0] let_q, let_d;
    logic [1:0] nf_q, nf_d;
    logic ten_q, ten_d;
    logic [16:0] f0_q, f0_d, f1_q, f1_d;
    logic [7:0] slot_byte;
    logic slot_emit;

    // ascii digit n (0 = units) of a decimal value
    function automatic logic [7:0] dchar(input logic [16:0] v,
                                         input logic [2:0] n);
        logic [16:0] q;
        logic [16:0] r;
        case (n)
            3'h0: q = v;
            3'h1: q = v / 17'h0000a;
            3'h2: q = v / 17'h00064;
            3'h3: q = v / 17'h003e8;
            default: q = v / 17'h02710;
        endcase
        r = q % 17'h0000a;
        return cmd_pkg::CH_0 + {4'h0, r[3:0]};
    endfunction

    // byte for the current slot and whether it is sent
    always_comb begin
        logic [16:0] fv;
        logic [3:0] k;
        fv = 17'h00000;
        k = 4'h0;
        slot_byte = let_q;
        slot_emit = 1'b1;
        if (pos_q == cmd_pkg::SLOT_CR) begin
            slot_byte = cmd_pkg::CH_CR;
        end else if (pos_q == cmd_pkg::SLOT_LAST) begin
            slot_byte = cmd_pkg::CH_LF;
        end else if (pos_q != 4'h0) begin
            fv = (pos_q >= cmd_pkg::SLOT_FIELD1) ? f1_q : f0_q;
            k = (pos_q >= cmd_pkg::SLOT_FIELD1) ?
                pos_q - cmd_pkg::SLOT_FIELD1 : pos_q - cmd_pkg::SLOT_FIELD0;
            slot_emit = (pos_q >= cmd_pkg::SLOT_FIELD1) ? (nf_q == 2'h2)
                                                        : (nf_q != 2'h0);
            if (k == 4'h0) begin
                slot_byte = cmd_pkg::CH_SP;
            end else if (!ten_q) begin
                slot_byte = dchar(fv, 3'(4'h5 - k));
            end else begin
                // tenths shown as [t]u.f to mirror the interval input
                case (k)
                    4'h2: begin
                        slot_byte = dchar(fv, 3'h2);
                        slot_emit = slot_emit && (fv >= 17'h00064);
                    end
                    4'h3: slot_byte = dchar(fv, 3'h1);
                    4'h4: slot_byte = cmd_pkg::CH_DOT;
                    4'h5: slot_byte = dchar(fv, 3'h0);
                    default: slot_emit = 1'b0;
                endcase
            end
        end
    end

    // walk the slots, holding each emitted byte until it is taken
    always_comb begin
        active_d = active_q;
        valid_d = valid_q;
        byte_d = byte_q;
        pos_d = pos_q;
        let_d = let_q;
        nf_d = nf_q;
        ten_d = ten_q;
        f0_d = f0_q;
        f1_d = f1_q;
        if (valid_q && tx_ready) begin
            valid_d = 1'b0;
        end
        if (start && !busy) begin
            active_d = 1'b1;
            pos_d = 4'h0;
            let_d = letter;
            nf_d = nfield;
            ten_d = fmt_tenths;
            f0_d = field0;
            f1_d = field1;
        end else if (active_q && (!valid_q || tx_ready)) begin
            valid_d = slot_emit;
            byte_d = slot_emit ? slot_byte : byte_q;
            pos_d = pos_q + 4'h1;
            if (pos_q == cmd_pkg::SLOT_LAST) begin
                active_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            active_q <= 1'b0;
            valid_q <= 1'b0;
            byte_q <= 8'h00;
            pos_q <= 4'h0;
            let_q <= 8'h00;
            nf_q <= 2'h0;
            ten_q <= 1'b0;
            f0_q <= 17'h00000;
            f1_q <= 17'h00000;
        end else begin
            active_q <= active_d;
            valid_q <= valid_d;
            byte_q <= byte_d;
            pos_q <= pos_d;
            let_q <= let_d;
            nf_q <= nf_d;
            ten_q <= ten_d;
            f0_q <= f0_d;
            f1_q <= f1_d;
        end
    end

    assign busy = active_q || valid_q;
    assign tx_data = byte_q;
    assign tx_valid = valid_q;
endmodule

// >>> pkg/cmd_pkg.sv
// Functional notes
// - X command is 'X', space, decimal, CR LF.
// - X recalibrates zero, replies letter and zero.
// - X concentration scaled by multiplier; P bytes stored unscaled.
// - P 8 high byte, P 9 low byte.
// - two-byte concentration is high*256 plus low.
// - P 10 high, P 11 low fresh-air concentration.
// - S command stores altitude value, echoes it.
// - altitude defaults 8192, range 0 to 65536.
// - s command replies current altitude value.
// - @ stores both intervals, mirrors them back.
// - intervals in days, one decimal; zero disables.
// - concentration multiplier is always one.
// - G calibrates using fresh-air concentration setting.
package cmd_pkg;
    // character codes
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_SR = 8'h73;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    // value widths and limits
    localparam int VAL_W = 17;
    localparam int CONC_W = 16;
    localparam int TENTHS_W = 10;
    localparam logic [16:0] IDX_BG_HI = 17'h00008;
    localparam logic [16:0] IDX_BG_LO = 17'h00009;
    localparam logic [16:0] IDX_FA_HI = 17'h0000a;
    localparam logic [16:0] IDX_FA_LO = 17'h0000b;
    localparam logic [16:0] BYTE_MAX = 17'h000ff;
    localparam logic [16:0] CONC_MAX = 17'h0ffff;
    localparam logic [16:0] ALT_MAX = 17'h10000;
    localparam logic [16:0] TENTHS_MAX = 17'h003e7;
    localparam logic [16:0] CONC_MULT = 17'h00001;
    // values after reset
    localparam logic [16:0] ALT_RESET = 17'h02000;
    localparam logic [15:0] CONC_RESET = 16'h0190;
    localparam logic [9:0] TENTHS_RESET = 10'h000;
    // reply layout: letter, two fields of six slots, CR, LF
    localparam logic [3:0] SLOT_FIELD0 = 4'h1;
    localparam logic [3:0] SLOT_FIELD1 = 4'h7;
    localparam logic [3:0] SLOT_CR = 4'hd;
    localparam logic [3:0] SLOT_LAST = 4'he;

    typedef enum logic [2:0] {
        ST_LETTER = 3'b000,
        ST_BODY = 3'b001,
        ST_LF = 3'b010,
        ST_DISCARD = 3'b011,
        ST_CAL = 3'b100
    } parse_st_t;
endpackage
